// >>> hw/swdt_top.sv
`timescale 1ns/1ps

module swdt_top
#(
    parameter int OSC_DIV = swdt_pkg::OSC_DIV_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host watchdog kick
    input wire logic watchdog_kick_in,
    // Analog front end status
    input wire logic supply_valid,
    input wire logic kick_floating,
    // Timebase configuration pins
    input wire logic timebase_source_select,
    input wire logic timebase_timing_in,
    input wire logic reduced_variant,
    // RAM chip-select gating
    input wire logic chip_select_in_n,
    output logic chip_select_out_n,
    // Supervisor outputs
    output logic reset_out_n,
    output logic timeout_flag_n,
    // Status
    output logic long_period_active,
    output swdt_pkg::swdt_cnt_t watch_count
);

    import swdt_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic kick_sync;
    logic float_sync;
    logic src_sel_sync;
    logic timing_sync;
    logic reduced_sync;
    logic cs_in_sync;

    swdt_sync #(.RESET_VALUE(1'b0)) u_sync_kick
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(watchdog_kick_in),
        .sync_out(kick_sync)
    );

    swdt_sync #(.RESET_VALUE(1'b0)) u_sync_float
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(kick_floating),
        .sync_out(float_sync)
    );

    // Floating select reads high, so high is the safe reset level
    swdt_sync #(.RESET_VALUE(1'b1)) u_sync_src
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(timebase_source_select),
        .sync_out(src_sel_sync)
    );

    swdt_sync #(.RESET_VALUE(1'b1)) u_sync_timing
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(timebase_timing_in),
        .sync_out(timing_sync)
    );

    swdt_sync #(.RESET_VALUE(1'b0)) u_sync_reduced
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(reduced_variant),
        .sync_out(reduced_sync)
    );

    swdt_sync #(.RESET_VALUE(1'b1)) u_sync_cs
    (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(chip_select_in_n),
        .sync_out(cs_in_sync)
    );

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic kick_prev_ff;
    logic timing_prev_ff;
    logic kick_edge;
    logic ext_clk_rise;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            kick_prev_ff <= 1'b0;
            timing_prev_ff <= 1'b1;
        end
        else
        begin
            kick_prev_ff <= kick_sync;
            timing_prev_ff <= timing_sync;
        end
    end

    // Either polarity counts as a kick
    assign kick_edge = kick_sync ^ kick_prev_ff;
    assign ext_clk_rise = timing_sync & ~timing_prev_ff;

    // ----------------------------------------------------------------
    // Enable and timebase selection
    // ----------------------------------------------------------------
    logic wd_enable;
    logic use_internal;

    // Timer stops while the kick pin floats or supply is bad
    assign wd_enable = supply_valid & ~float_sync;
    // The reduced variant has no select pins: always internal
    assign use_internal = src_sel_sync | reduced_sync;

    // ----------------------------------------------------------------
    // Internal oscillator prescaler
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] presc_ff;
    logic int_tick_ff;
    logic [CNT_W-1:0] presc_last;

    assign presc_last = CNT_W'(OSC_DIV - 1);

    // Free running so that the tick phase does not jitter on enable
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            presc_ff <= CNT_RESET;
            int_tick_ff <= 1'b0;
        end
        else if (presc_ff >= presc_last)
        begin
            presc_ff <= CNT_RESET;
            int_tick_ff <= 1'b1;
        end
        else
        begin
            presc_ff <= presc_ff + 16'h0001;
            int_tick_ff <= 1'b0;
        end
    end

    logic tick;

    // One timebase tick: oscillator period or external clock edge
    assign tick = use_internal ? int_tick_ff : ext_clk_rise;

    // ----------------------------------------------------------------
    // Terminal values
    // ----------------------------------------------------------------
    logic long_ff;
    swdt_cnt_t normal_limit;
    swdt_cnt_t long_limit;
    swdt_cnt_t pulse_limit;
    swdt_cnt_t watch_limit;

    always_comb
    begin
        if (reduced_sync)
        begin
            normal_limit = INT_POST_RESET_TICKS;
            long_limit = INT_POST_RESET_TICKS;
            pulse_limit = INT_PULSE_TICKS;
        end
        else if (!use_internal)
        begin
            normal_limit = EXT_NORMAL_CLKS;
            long_limit = EXT_POST_RESET_CLKS;
            pulse_limit = EXT_PULSE_CLKS;
        end
        else
        begin
            // Timing pin selects short or long normal period
            normal_limit = timing_sync ? INT_NORMAL_LONG_TICKS
                                       : INT_NORMAL_SHORT_TICKS;
            long_limit = INT_POST_RESET_TICKS;
            pulse_limit = INT_PULSE_TICKS;
        end
    end

    // Single counter, terminal picked by phase
    assign watch_limit = long_ff ? long_limit : normal_limit;

    // ----------------------------------------------------------------
    // Watchdog state machine
    // ----------------------------------------------------------------
    swdt_state_e state_ff;
    swdt_cnt_t watch_cnt_ff;
    swdt_cnt_t pulse_cnt_ff;
    swdt_cnt_t nxt_watch_cnt;
    swdt_cnt_t nxt_pulse_cnt;
    logic watch_expire;
    logic pulse_done;

    assign nxt_watch_cnt = watch_cnt_ff + 16'h0001;
    assign nxt_pulse_cnt = pulse_cnt_ff + 16'h0001;
    assign watch_expire = tick && (nxt_watch_cnt >= watch_limit);
    assign pulse_done = tick && (nxt_pulse_cnt >= pulse_limit);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= SWDT_ST_WATCH;
        end
        else if (!wd_enable)
        begin
            state_ff <= SWDT_ST_OFF;
        end
        else
        begin
            case (state_ff)
                SWDT_ST_OFF:
                begin
                    state_ff <= SWDT_ST_WATCH;
                end
                SWDT_ST_WATCH:
                begin
                    if (!kick_edge && watch_expire)
                    begin
                        state_ff <= SWDT_ST_PULSE;
                    end
                end
                SWDT_ST_PULSE:
                begin
                    if (pulse_done)
                    begin
                        state_ff <= SWDT_ST_WATCH;
                    end
                end
                default:
                begin
                    state_ff <= SWDT_ST_OFF;
                end
            endcase
        end
    end

    // Timeout counter
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            watch_cnt_ff <= CNT_RESET;
        end
        else if (state_ff != SWDT_ST_WATCH || !wd_enable)
        begin
            // Held at zero so counting restarts on release
            watch_cnt_ff <= CNT_RESET;
        end
        else if (kick_edge || watch_expire)
        begin
            watch_cnt_ff <= CNT_RESET;
        end
        else if (tick)
        begin
            watch_cnt_ff <= nxt_watch_cnt;
        end
    end

    // Reset pulse counter
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_cnt_ff <= CNT_RESET;
        end
        else if (state_ff != SWDT_ST_PULSE || !wd_enable)
        begin
            pulse_cnt_ff <= CNT_RESET;
        end
        else if (tick)
        begin
            pulse_cnt_ff <= nxt_pulse_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Post-reset long period
    // ----------------------------------------------------------------
    // Kicks during the pulse are ignored, so a host still
    // booting cannot shorten the first period by accident
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            long_ff <= 1'b1;
        end
        else if (!wd_enable || state_ff == SWDT_ST_PULSE)
        begin
            long_ff <= 1'b1;
        end
        else if (state_ff == SWDT_ST_WATCH && kick_edge)
        begin
            long_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reset_out_n <= 1'b1;
        end
        else if (!wd_enable)
        begin
            reset_out_n <= 1'b1;
        end
        else
        begin
            reset_out_n <= ~((state_ff == SWDT_ST_WATCH && !kick_edge &&
                              watch_expire) ||
                             (state_ff == SWDT_ST_PULSE &&
                              !pulse_done));
        end
    end

    // Flag: a kick edge wins over expiry in the same cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timeout_flag_n <= 1'b1;
        end
        else if (!supply_valid)
        begin
            timeout_flag_n <= 1'b1;
        end
        else if (wd_enable && state_ff == SWDT_ST_WATCH &&
                 !kick_edge && watch_expire)
        begin
            timeout_flag_n <= 1'b0;
        end
        else if (wd_enable && kick_edge)
        begin
            timeout_flag_n <= 1'b1;
        end
    end

    // Back-up mode keeps the load off the RAM or battery
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chip_select_out_n <= 1'b1;
        end
        else if (!supply_valid)
        begin
            chip_select_out_n <= 1'b1;
        end
        else
        begin
            chip_select_out_n <= cs_in_sync;
        end
    end

    // Status mirrors
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            long_period_active <= 1'b1;
            watch_count <= CNT_RESET;
        end
        else
        begin
            long_period_active <= long_ff;
            watch_count <= watch_cnt_ff;
        end
    end

endmodule

// >>> common/swdt_pkg.sv
package swdt_pkg;

    // ----------------------------------------------------------------
    // Clock and timebase
    // ----------------------------------------------------------------
    localparam int CORE_CLK_HZ = 250_000_000;
    // Internal oscillator, 10.24 kHz
    localparam int INT_OSC_HZ = 10_240;
    localparam int OSC_DIV_CYCLES = (CORE_CLK_HZ + INT_OSC_HZ / 2)
                                    / INT_OSC_HZ;

    // ----------------------------------------------------------------
    // Internal oscillator intervals, nominal
    // ----------------------------------------------------------------
    localparam int T_NORMAL_SHORT_MS = 100;
    localparam int T_NORMAL_LONG_MS = 1600;
    localparam int T_POST_RESET_MS = 1600;
    localparam int T_PULSE_MS = 200;

    // Guaranteed minimum figures
    localparam int T_NORMAL_MIN_MS = 70;
    localparam int T_POST_RESET_MIN_MS = 1000;
    localparam int T_PULSE_MIN_MS = 140;

    // ----------------------------------------------------------------
    // Counter layout
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;
    typedef logic [CNT_W-1:0] swdt_cnt_t;

    localparam swdt_cnt_t INT_NORMAL_SHORT_TICKS =
        swdt_cnt_t'(T_NORMAL_SHORT_MS * INT_OSC_HZ / 1000);
    localparam swdt_cnt_t INT_NORMAL_LONG_TICKS =
        swdt_cnt_t'(T_NORMAL_LONG_MS * INT_OSC_HZ / 1000);
    localparam swdt_cnt_t INT_POST_RESET_TICKS =
        swdt_cnt_t'(T_POST_RESET_MS * INT_OSC_HZ / 1000);
    localparam swdt_cnt_t INT_PULSE_TICKS =
        swdt_cnt_t'(T_PULSE_MS * INT_OSC_HZ / 1000);

    // External clock counts
    localparam swdt_cnt_t EXT_NORMAL_CLKS = 16'h0400;
    localparam swdt_cnt_t EXT_POST_RESET_CLKS = 16'h1000;
    localparam swdt_cnt_t EXT_PULSE_CLKS = 16'h0800;

    // ----------------------------------------------------------------
    // Reset values and states
    // ----------------------------------------------------------------
    localparam swdt_cnt_t CNT_RESET = 16'h0000;

    typedef enum logic [1:0]
    {
        SWDT_ST_OFF = 2'b00,
        SWDT_ST_WATCH = 2'b01,
        SWDT_ST_PULSE = 2'b10
    } swdt_state_e;

endpackage

// >>> hw/swdt_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for one asynchronous level
module swdt_sync
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_ff <= RESET_VALUE;
            sync_ff <= RESET_VALUE;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// >>> tb/swdt_checker.sv
`timescale 1ns/1ps

module swdt_checker
#(
    parameter int OSC_DIV = 4
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Inputs
    input wire logic watchdog_kick_in,
    input wire logic supply_valid,
    input wire logic kick_floating,
    input wire logic timebase_source_select,
    input wire logic timebase_timing_in,
    input wire logic reduced_variant,
    input wire logic chip_select_in_n,
    // Outputs
    input wire logic chip_select_out_n,
    input wire logic reset_out_n,
    input wire logic timeout_flag_n,
    input wire logic long_period_active,
    input wire swdt_pkg::swdt_cnt_t watch_count
);
    import swdt_pkg::*;

    localparam int P_CLKS = int'(INT_PULSE_TICKS) * OSC_DIV;
    localparam int P_EXT = int'(EXT_PULSE_CLKS);

    // ------------------------------------------------------------
    // Pulse and kick bookkeeping
    // ------------------------------------------------------------
    int low_clk_ff;
    int low_ext_ff;
    int kick_age_ff;
    logic ext_ff;
    logic kick_ff;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            low_clk_ff <= 0;
            low_ext_ff <= 0;
            ext_ff <= 1'b0;
        end
        else
        begin
            ext_ff <= timebase_timing_in;
            low_clk_ff <= reset_out_n ? 0 : low_clk_ff + 1;
            low_ext_ff <= reset_out_n ? 0
                : low_ext_ff + int'(timebase_timing_in && !ext_ff);
        end
    end

    // Saturates, so a stale kick never excuses a late change
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            kick_age_ff <= 1000;
            kick_ff <= 1'b0;
        end
        else
        begin
            kick_ff <= watchdog_kick_in;
            if (watchdog_kick_in != kick_ff)
                kick_age_ff <= 0;
            else if (kick_age_ff < 1000)
                kick_age_ff <= kick_age_ff + 1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    supply_off_a: assert property (
        !supply_valid |=> reset_out_n && timeout_flag_n && chip_select_out_n)
        else $error("outputs not forced on invalid supply");
    cs_follow_a: assert property (
        (supply_valid && $stable(chip_select_in_n))[*4]
        |-> chip_select_out_n == chip_select_in_n)
        else $error("chip select not following");
    pulse_int_a: assert property (
        $rose(reset_out_n) && supply_valid && $past(supply_valid)
        && timebase_source_select
        |-> low_clk_ff >= P_CLKS - OSC_DIV && low_clk_ff <= P_CLKS + OSC_DIV)
        else $error("internal pulse length wrong");
    pulse_ext_a: assert property (
        $rose(reset_out_n) && supply_valid && $past(supply_valid)
        && !timebase_source_select
        |-> low_ext_ff >= P_EXT - 1 && low_ext_ff <= P_EXT + 1)
        else $error("external pulse length wrong");
    long_set_a: assert property (
        $rose(reset_out_n) && supply_valid |-> ##[0:2] long_period_active)
        else $error("long period not set after pulse");
    long_drop_a: assert property (
        $fell(long_period_active) && supply_valid |-> kick_age_ff <= 8)
        else $error("long period left without kick");
    kick_clr_a: assert property (
        $changed(watchdog_kick_in) && reset_out_n && supply_valid
        && !kick_floating && !$past(kick_floating, 4)
        |-> ##[3:7] watch_count == CNT_RESET)
        else $error("kick did not clear count");
    flag_low_a: assert property (
        $fell(reset_out_n) |-> !timeout_flag_n)
        else $error("flag not low on expiry");

    rst_fall_c: cover property ($fell(reset_out_n));
    long_fall_c: cover property ($fell(long_period_active));
    supply_off_c: cover property (!supply_valid && !timeout_flag_n);
endmodule

// >>> tb/swdt_host_model.sv
`timescale 1ns/1ps

module swdt_host_model
(
    // Clock
    input wire logic core_clk,
    // Host control
    input wire logic kick_en,
    input wire logic float_en,
    input wire logic [15:0] kick_gap,
    // Kick pin
    output logic watchdog_kick_in
);
    logic [15:0] gap_ff;

    initial
    begin
        watchdog_kick_in = 1'b0;
        gap_ff = 16'h0000;
    end

    always @(negedge core_clk)
    begin
        if (float_en)
        begin
            // Open pin: front end flags it, level sits still
            watchdog_kick_in <= watchdog_kick_in;
        end
        else if (kick_en && gap_ff == 16'h0000)
        begin
            watchdog_kick_in <= ~watchdog_kick_in;
            gap_ff <= kick_gap;
        end
        else
        begin
            gap_ff <= kick_en ? gap_ff - 16'h0001 : 16'h0000;
        end
    end
endmodule

// >>> tb/swdt_top_tb.sv
`timescale 1ns/1ps

module swdt_top_tb;
    import swdt_pkg::*;

    localparam int OSC_DIV = 4;
    localparam int EXT_DIV = 2;
    localparam int CYC_LIMIT = 80000;
    localparam int LONG = int'(EXT_POST_RESET_CLKS) * EXT_DIV;
    localparam int NORM = int'(EXT_NORMAL_CLKS) * EXT_DIV;
    localparam int PULSE = int'(EXT_PULSE_CLKS) * EXT_DIV;
    localparam int INORM = int'(INT_NORMAL_SHORT_TICKS) * OSC_DIV;
    localparam int IPULSE = int'(INT_PULSE_TICKS) * OSC_DIV;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic supply_valid = 1'b1;
    logic kick_floating = 1'b0;
    logic src_sel = 1'b0;
    logic tim_lvl = 1'b0;
    logic ext_run = 1'b1;
    logic cs_in_n = 1'b1;
    logic kick_en = 1'b0;
    logic ext_div = 1'b0;
    logic reduced_var = 1'b0;
    logic kick;
    logic timing_in;
    logic cs_out_n;
    logic rst_out_n;
    logic flag_n;
    logic long_act;
    swdt_cnt_t count;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    // External timebase, one rising edge every EXT_DIV clocks
    assign timing_in = ext_run ? ext_div : tim_lvl;

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
    begin
        ext_div <= ~ext_div;
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT)
        begin
            err_total++;
            wrap_up();
        end
    end

    swdt_host_model host
    (
        .core_clk(core_clk), .kick_en(kick_en), .float_en(kick_floating),
        .kick_gap(16'h0257), .watchdog_kick_in(kick)
    );

    swdt_top #(.OSC_DIV(OSC_DIV)) uut
    (
        .core_clk(core_clk), .rst_b(rst_b), .watchdog_kick_in(kick),
        .supply_valid(supply_valid), .kick_floating(kick_floating),
        .timebase_source_select(src_sel), .timebase_timing_in(timing_in),
        .reduced_variant(reduced_var), .chip_select_in_n(cs_in_n),
        .chip_select_out_n(cs_out_n), .reset_out_n(rst_out_n),
        .timeout_flag_n(flag_n), .long_period_active(long_act),
        .watch_count(count)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_bit(logic got, logic exp, string what);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task automatic chk_range(int got, int lo, int hi, string what);
        n_tests++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("Error at %0t: %s took %0d", $time, what, got);
        end
    endtask

    task automatic idle(int k);
        repeat (k) @(negedge core_clk);
    endtask

    // Model toggles the pin on the negedge this task returns at
    task automatic kick_once();
        kick_en <= 1'b1;
        @(negedge core_clk);
        kick_en <= 1'b0;
    endtask

    // Cycles until the reset output reaches lvl, capped at max
    task automatic wait_lvl(logic lvl, int max);
        n = 0;
        while (rst_out_n !== lvl && n < max)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        idle(6);
        rst_b <= 1'b1;
        wait_lvl(1'b0, 20000);
        chk_range(n, LONG - 4, LONG + 16, "long timeout");
        chk_bit(flag_n, 1'b0, "flag on expiry");
        wait_lvl(1'b1, 20000);
        chk_range(n, PULSE - 8, PULSE + 8, "pulse");
        chk_bit(long_act, 1'b1, "long after pulse");
        $display("Test 1 done");
        kick_once();
        idle(8);
        chk_bit(long_act, 1'b0, "long after kick");
        chk_bit(flag_n, 1'b1, "flag after kick");
        kick_en <= 1'b1;
        wait_lvl(1'b0, 6000);
        chk_range(n, 6000, 6000, "kicked run");
        kick_en <= 1'b0;
        idle(1);
        kick_once();
        wait_lvl(1'b0, 6000);
        chk_range(n, NORM - 4, NORM + 16, "normal timeout");
        wait_lvl(1'b1, 20000);
        wait_lvl(1'b0, 20000);
        chk_range(n, LONG - 4, LONG + 16, "repeat");
        wait_lvl(1'b1, 20000);
        $display("Test 2 done");
        cs_in_n <= 1'b0;
        idle(6);
        chk_bit(cs_out_n, 1'b0, "chip select pass");
        supply_valid <= 1'b0;
        idle(2);
        chk_bit(flag_n, 1'b1, "flag forced high");
        chk_bit(cs_out_n, 1'b1, "chip select gated");
        // Kick first, so a live timer would expire in the normal period
        supply_valid <= 1'b1;
        idle(10);
        kick_once();
        idle(10);
        supply_valid <= 1'b0;
        wait_lvl(1'b0, 5000);
        chk_range(n, 5000, 5000, "supply invalid");
        supply_valid <= 1'b1;
        idle(6);
        chk_bit(cs_out_n, 1'b0, "chip select back");
        cs_in_n <= 1'b1;
        idle(10);
        kick_once();
        $display("Test 3 done");
        idle(10);
        kick_floating <= 1'b1;
        wait_lvl(1'b0, 5000);
        chk_range(n, 5000, 5000, "floating kick");
        kick_floating <= 1'b0;
        idle(10);
        $display("Test 4 done");
        src_sel <= 1'b1;
        ext_run <= 1'b0;
        kick_once();
        wait_lvl(1'b0, 6000);
        chk_range(n, INORM - 8, INORM + 16, "int short");
        wait_lvl(1'b1, 20000);
        chk_range(n, IPULSE - 8, IPULSE + 8, "int pulse");
        $display("Test 5 done");
        // A short period here would expire well inside the wait
        tim_lvl <= 1'b1;
        kick_once();
        wait_lvl(1'b0, 5000);
        chk_range(n, 5000, 5000, "int long normal");
        // Pins ask for the external clock; the reduced variant ignores them
        reduced_var <= 1'b1;
        src_sel <= 1'b0;
        ext_run <= 1'b1;
        kick_once();
        wait_lvl(1'b0, 5000);
        chk_range(n, 5000, 5000, "reduced variant");
        $display("Test 6 done");
        wrap_up();
    end
endmodule

bind swdt_top swdt_checker #(.OSC_DIV(OSC_DIV)) u_chk
(
    .core_clk(core_clk), .rst_b(rst_b),
    .watchdog_kick_in(watchdog_kick_in), .supply_valid(supply_valid),
    .kick_floating(kick_floating),
    .timebase_source_select(timebase_source_select),
    .timebase_timing_in(timebase_timing_in),
    .reduced_variant(reduced_variant), .chip_select_in_n(chip_select_in_n),
    .chip_select_out_n(chip_select_out_n), .reset_out_n(reset_out_n),
    .timeout_flag_n(timeout_flag_n), .long_period_active(long_period_active),
    .watch_count(watch_count)
);
